// >>> rtl/ebpwm_channel.sv
// eight-bit pwm channel with avalon-mm register slave
//
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - polarity select high inverts the active level
// - reserved control bits ignore writes, read one
// - selector picks divide 2,8,32,128,256,1024,2048,4096
// - period is 250 counter clocks
// - counter steps on prescaler falling edge
// - disabled: counter held zero, output suppressed
// - disabled: duty write takes effect at once
// - enabled: counter starts from zero
// - output goes active on count zero to one
// - output goes inactive when count passes duty
// - enabled: duty write waits for counter wrap
// - duty zero keeps output inactive
// - duty 250 to 255 keeps output active
// - counter runs 0 to 249 then wraps
// - duty read returns the active value
// - counter cleared on reset and disable
// - duty resets to all ones
module ebpwm_channel (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             pulse_out_ch0,
  output logic             pulse_out_ch0_en
);

  typedef struct packed {
    logic        oe;
    logic        polarity_select;
    logic [2:0]  cks;
    logic [7:0]  duty_act;
    logic [7:0]  duty_buf;
    logic [7:0]  pwm_count;
    logic        active;
    logic        pin;
    logic        ack;
    logic [31:0] rdata;
  } ebpwm_state_t;

  localparam ebpwm_state_t EBPWM_STATE_RST = '{
    oe:              ebpwm_pkg::EBPWM_CTRL_RST[ebpwm_pkg::EBPWM_CTRL_OE_BIT],
    polarity_select: ebpwm_pkg::EBPWM_CTRL_RST[ebpwm_pkg::EBPWM_CTRL_POL_BIT],
    cks:             ebpwm_pkg::EBPWM_CTRL_RST[2:0],
    duty_act:        ebpwm_pkg::EBPWM_DUTY_RST,
    duty_buf:        ebpwm_pkg::EBPWM_DUTY_RST,
    pwm_count:       ebpwm_pkg::EBPWM_COUNT_RST,
    active:          1'b0,
    pin:             1'b0,
    ack:             1'b0,
    rdata:           32'h0000_0000
  };

  ebpwm_state_t s_r;
  ebpwm_state_t s_nxt;
  logic         tick;
  logic         req;
  logic         wr_acc;
  logic         run;
  logic [7:0]   ctrl_view;

  // address decode shared by the read mux, the writes and the checks
  function automatic logic ebpwm_hit(input logic [3:0] addr, input logic [3:0] ofs);
    ebpwm_hit = (addr == ofs);
  endfunction

  ebpwm_prescaler #(
    .WIDTH (ebpwm_pkg::EBPWM_PRESC_W)
  ) u_presc (
    .clk                  (clk),
    .rst_n                (rst_n),
    .clock_divider_select (s_r.cks),
    .tick                 (tick)
  );

  // reserved bits are not stored at all, so writes cannot reach them
  always_comb begin
    ctrl_view = {s_r.oe, s_r.polarity_select, ebpwm_pkg::EBPWM_RSV_ONES, s_r.cks};
  end

  always_comb begin
    s_nxt  = s_r;
    req    = avs_read | avs_write;
    // one wait state: the read mux is registered in the first cycle
    // a write lands only in the answering cycle, so a held request applies once
    wr_acc = avs_write & s_r.ack;
    s_nxt.ack = req & ~s_r.ack;
    if (req && !s_r.ack) begin
      s_nxt.rdata = 32'h0000_0000;
      if (ebpwm_hit(avs_address, ebpwm_pkg::EBPWM_OFS_CTRL)) begin
        s_nxt.rdata[7:0] = ctrl_view;
      end else if (ebpwm_hit(avs_address, ebpwm_pkg::EBPWM_OFS_DUTY)) begin
        s_nxt.rdata[7:0] = s_r.duty_act;
      end else if (ebpwm_hit(avs_address, ebpwm_pkg::EBPWM_OFS_COUNT)) begin
        s_nxt.rdata[7:0] = s_r.pwm_count;
      end
    end

    // register writes; only byte lane 0 carries data
    if (wr_acc && avs_byteenable[0]) begin
      if (ebpwm_hit(avs_address, ebpwm_pkg::EBPWM_OFS_CTRL)) begin
        s_nxt.oe              = avs_writedata[ebpwm_pkg::EBPWM_CTRL_OE_BIT];
        s_nxt.polarity_select = avs_writedata[ebpwm_pkg::EBPWM_CTRL_POL_BIT];
        s_nxt.cks             = avs_writedata[2:0];
      end else if (ebpwm_hit(avs_address, ebpwm_pkg::EBPWM_OFS_DUTY)) begin
        s_nxt.duty_buf = avs_writedata[7:0];
        if (!s_r.oe) begin
          s_nxt.duty_act = avs_writedata[7:0];
        end
      end
    end

    // the counter only runs when enabled both before and after this edge,
    // so a fresh enable always starts from zero
    run = s_r.oe & s_nxt.oe;
    if (!s_nxt.oe) begin
      s_nxt.pwm_count = ebpwm_pkg::EBPWM_COUNT_RST;
      s_nxt.active    = 1'b0;
    end else if (run && tick) begin
      if (s_r.pwm_count == ebpwm_pkg::EBPWM_COUNT_TOP) begin
        s_nxt.pwm_count = ebpwm_pkg::EBPWM_COUNT_RST;
        // loading on the wrap step keeps every period on a single duty value
        s_nxt.duty_act  = s_r.duty_buf;
      end else begin
        s_nxt.pwm_count = s_r.pwm_count + 8'h01;
      end
      if (s_r.pwm_count == ebpwm_pkg::EBPWM_COUNT_RST) begin
        s_nxt.active = (s_r.duty_act != ebpwm_pkg::EBPWM_DUTY_ZERO);
      end else if (s_r.pwm_count == s_r.duty_act) begin
        // duty of 250..255 never matches, so the level stays active
        s_nxt.active = 1'b0;
      end
    end

    // pin is registered from the next state so it moves together with the count
    s_nxt.pin = s_nxt.oe & (s_nxt.active ^ s_nxt.polarity_select);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= EBPWM_STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_waitrequest  = req & ~s_r.ack;
  assign avs_readdata     = s_r.rdata;
  assign pulse_out_ch0    = s_r.pin;
  // when disabled the pin returns to the general purpose port
  assign pulse_out_ch0_en = s_r.oe;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_pin_polarity: assert property (
    s_r.oe |-> (pulse_out_ch0 == (s_r.active ^ s_r.polarity_select))
  ) else $error("pulse pin does not follow polarity select");

  chk_reserved_ones: assert property (
    (avs_read && !avs_waitrequest && ebpwm_hit(avs_address, ebpwm_pkg::EBPWM_OFS_CTRL))
      |-> (avs_readdata[5:3] == 3'h7)
  ) else $error("reserved control bits did not read as ones");

  chk_disabled_idle: assert property (
    !s_r.oe |-> (s_r.pwm_count == 8'h00 && !pulse_out_ch0 && !pulse_out_ch0_en)
  ) else $error("disabled channel not idle");

  chk_count_wrap: assert property (
    (s_r.oe && tick && s_r.pwm_count == 8'hF9 && !wr_acc) |=> (s_r.pwm_count == 8'h00)
  ) else $error("counter did not wrap after 249");

  chk_count_step: assert property (
    (s_r.oe && tick && s_r.pwm_count != 8'hF9 && !wr_acc)
      |=> (s_r.pwm_count == $past(s_r.pwm_count) + 8'h01)
  ) else $error("counter did not step on prescaler edge");

  chk_count_still: assert property (
    (s_r.oe && !tick && !wr_acc) |=> $stable(s_r.pwm_count)
  ) else $error("counter moved without a prescaler edge");

  chk_rise_at_one: assert property (
    (s_r.oe && tick && !wr_acc && s_r.pwm_count == 8'h00 && s_r.duty_act != 8'h00)
      |=> s_r.active
  ) else $error("output did not go active at count one");

  chk_match_fall: assert property (
    (s_r.oe && tick && !wr_acc && s_r.pwm_count != 8'h00 && s_r.pwm_count == s_r.duty_act)
      |=> !s_r.active
  ) else $error("output did not go inactive after compare match");

  chk_zero_duty: assert property (
    (s_r.oe && s_r.duty_act == 8'h00 && s_r.pwm_count != 8'h00) |-> !s_r.active
  ) else $error("zero duty produced an active level");

  chk_full_duty: assert property (
    (s_r.oe && s_r.duty_act >= 8'hFA && s_r.pwm_count != 8'h00) |-> s_r.active
  ) else $error("full duty produced an inactive level");

  chk_duty_direct: assert property (
    (wr_acc && avs_byteenable[0] && !s_r.oe
      && ebpwm_hit(avs_address, ebpwm_pkg::EBPWM_OFS_DUTY))
      |=> (s_r.duty_act == $past(avs_writedata[7:0]))
  ) else $error("duty write while disabled not applied at once");

  chk_duty_buffered: assert property (
    (s_r.oe && !(tick && s_r.pwm_count == 8'hF9)) |=> $stable(s_r.duty_act) || !s_r.oe
  ) else $error("active duty changed outside a counter wrap");

  chk_start_zero: assert property (
    $rose(s_r.oe) |-> (s_r.pwm_count == 8'h00)
  ) else $error("enabled counter did not start at zero");

  // bus slave: exactly one wait state, read data from a register
  chk_wait_once: assert property (
    (req && avs_waitrequest) |=> (!avs_waitrequest || !req)
  ) else $error("request held more than one wait state");

  chk_idle_ready: assert property (
    !req |-> !avs_waitrequest
  ) else $error("waitrequest raised without a request");

  chk_upper_zero: assert property (
    (avs_read && !avs_waitrequest) |-> (avs_readdata[31:8] == 24'h00_0000)
  ) else $error("upper read data bits not zero");

  // the read mux was loaded one edge before the answer, hence the past values
  chk_ctrl_readback: assert property (
    (avs_read && !avs_waitrequest && ebpwm_hit(avs_address, ebpwm_pkg::EBPWM_OFS_CTRL))
      |-> (avs_readdata[7:0] == {$past(s_r.oe), $past(s_r.polarity_select),
                                  ebpwm_pkg::EBPWM_RSV_ONES, $past(s_r.cks)})
  ) else $error("control read does not show the stored fields");

  chk_duty_readback: assert property (
    (avs_read && !avs_waitrequest && ebpwm_hit(avs_address, ebpwm_pkg::EBPWM_OFS_DUTY))
      |-> (avs_readdata[7:0] == $past(s_r.duty_act))
  ) else $error("duty read does not show the active value");

  chk_count_readback: assert property (
    (avs_read && !avs_waitrequest && ebpwm_hit(avs_address, ebpwm_pkg::EBPWM_OFS_COUNT))
      |-> (avs_readdata[7:0] == $past(s_r.pwm_count))
  ) else $error("count read does not show the counter");

  chk_lane_ignored: assert property (
    (wr_acc && !avs_byteenable[0])
      |=> ($stable(s_r.duty_buf) && $stable(s_r.polarity_select) && $stable(s_r.cks))
  ) else $error("write without byte lane zero changed a register");

  chk_cks_write: assert property (
    (wr_acc && avs_byteenable[0] && ebpwm_hit(avs_address, ebpwm_pkg::EBPWM_OFS_CTRL))
      |=> (s_r.cks == $past(avs_writedata[2:0]))
  ) else $error("clock selector write not stored");

  chk_buf_capture: assert property (
    (wr_acc && avs_byteenable[0] && ebpwm_hit(avs_address, ebpwm_pkg::EBPWM_OFS_DUTY))
      |=> (s_r.duty_buf == $past(avs_writedata[7:0]))
  ) else $error("duty write not captured in the buffer");

  // counter and output level
  chk_wrap_load: assert property (
    (s_r.oe && tick && !wr_acc && s_r.pwm_count == ebpwm_pkg::EBPWM_COUNT_TOP)
      |=> (s_r.duty_act == $past(s_r.duty_buf))
  ) else $error("buffered duty not loaded at counter wrap");

  chk_enable_quiet: assert property (
    $rose(s_r.oe) |-> !s_r.active
  ) else $error("output active at the enabling edge");

  chk_tick_single: assert property (
    tick |=> !tick
  ) else $error("prescaler tick longer than one clock");

  chk_active_held: assert property (
    (s_r.oe && !tick && !wr_acc) |=> $stable(s_r.active)
  ) else $error("output level changed without a counter step");

  chk_count_range: assert property (
    s_r.pwm_count <= ebpwm_pkg::EBPWM_COUNT_TOP
  ) else $error("counter left its 250-state range");

  chk_disable_clear: assert property (
    (wr_acc && avs_byteenable[0] && ebpwm_hit(avs_address, ebpwm_pkg::EBPWM_OFS_CTRL)
      && !avs_writedata[ebpwm_pkg::EBPWM_CTRL_OE_BIT])
      |=> (s_r.pwm_count == ebpwm_pkg::EBPWM_COUNT_RST && !pulse_out_ch0)
  ) else $error("clearing the enable did not stop the channel");

  cov_full_duty: cover property (
    s_r.oe && s_r.duty_act >= ebpwm_pkg::EBPWM_DUTY_FULL && tick);
  cov_wrap: cover property (s_r.oe && tick && s_r.pwm_count == 8'hF9);
  cov_buffered_write: cover property (
    wr_acc && s_r.oe && ebpwm_hit(avs_address, ebpwm_pkg::EBPWM_OFS_DUTY));
  cov_negative_pulse: cover property (s_r.oe && s_r.polarity_select && $fell(pulse_out_ch0));
  cov_fall_on_match: cover property (s_r.oe && $fell(s_r.active));

endmodule // ebpwm_channel

// >>> rtl/ebpwm_pkg.sv
// shared constants of the eight-bit pwm channel
package ebpwm_pkg;

  // register byte offsets on the avalon slave
  localparam logic [3:0] EBPWM_OFS_CTRL  = 4'h0;
  localparam logic [3:0] EBPWM_OFS_DUTY  = 4'h4;
  localparam logic [3:0] EBPWM_OFS_COUNT = 4'h8;

  // pwm_control field positions
  localparam int unsigned EBPWM_CTRL_OE_BIT  = 7;
  localparam int unsigned EBPWM_CTRL_POL_BIT = 6;
  localparam int unsigned EBPWM_CTRL_RSV_LSB = 3;
  localparam int unsigned EBPWM_CTRL_CKS_LSB = 0;

  // reset values
  localparam logic [7:0] EBPWM_CTRL_RST  = 8'h38;
  localparam logic [2:0] EBPWM_RSV_ONES  = 3'h7;
  localparam logic [7:0] EBPWM_DUTY_RST  = 8'hFF;
  localparam logic [7:0] EBPWM_COUNT_RST = 8'h00;

  // counter range: 0 .. 249, duty of 250 and above never matches
  localparam logic [7:0] EBPWM_COUNT_TOP = 8'hF9;
  localparam logic [7:0] EBPWM_DUTY_FULL = 8'hFA;
  localparam logic [7:0] EBPWM_DUTY_ZERO = 8'h00;

  // prescaler width: largest division is 4096 = 2**12
  localparam int unsigned EBPWM_PRESC_W = 12;

  // divider tap: divide by 2**(n) is bit n-1 of a free running counter
  // selector 0..7 picks /2 /8 /32 /128 /256 /1024 /2048 /4096
  function automatic logic [3:0] ebpwm_tap(input logic [2:0] sel);
    case (sel)
      3'h0:    ebpwm_tap = 4'h0;
      3'h1:    ebpwm_tap = 4'h2;
      3'h2:    ebpwm_tap = 4'h4;
      3'h3:    ebpwm_tap = 4'h6;
      3'h4:    ebpwm_tap = 4'h7;
      3'h5:    ebpwm_tap = 4'h9;
      3'h6:    ebpwm_tap = 4'hA;
      default: ebpwm_tap = 4'hB;
    endcase
  endfunction

endpackage

// >>> rtl/ebpwm_prescaler.sv
// prescaler: free running divider and falling-edge tick of the chosen tap
`timescale 1ns/1ps
module ebpwm_prescaler #(
  parameter int unsigned WIDTH = ebpwm_pkg::EBPWM_PRESC_W
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] clock_divider_select,
  output logic            tick
);

  typedef struct packed {
    logic [WIDTH-1:0] div;
    logic             tap_prev;
    logic             tick;
  } ebpwm_presc_t;

  ebpwm_presc_t s_r;
  ebpwm_presc_t s_nxt;
  logic         tap_now;

  always_comb begin
    s_nxt        = s_r;
    tap_now      = s_r.div[ebpwm_pkg::ebpwm_tap(clock_divider_select)];
    s_nxt.div    = s_r.div + {{(WIDTH-1){1'b0}}, 1'b1};
    s_nxt.tap_prev = tap_now;
    // a selector change can fake a falling edge; software avoids it by
    // choosing the division while the channel is disabled
    s_nxt.tick   = s_r.tap_prev & ~tap_now;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;

endmodule // ebpwm_prescaler

// >>> verification/ebpwm_load.sv
// external load model sitting on the pulse pin
`timescale 1ns/1ps
module ebpwm_load (
  input  wire logic clk,
  input  wire logic clr,
  input  wire logic pin,
  input  wire logic pin_en,
  output logic      level,
  output int        act_cnt
);
  // a pin handed back to gpio is seen at the pull-down level
  assign level = pin_en ? pin : 1'b0;
  always @(posedge clk) begin
    if (clr) begin
      act_cnt <= 0;
    end else if (level) begin
      act_cnt <= act_cnt + 1;
    end
  end
endmodule // ebpwm_load

// >>> verification/ebpwm_channel_tb.sv
// self-checking bench of the pwm channel
`timescale 1ns/1ps
module ebpwm_channel_tb;
  logic        clk;
  logic        rst_n;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        pulse_out_ch0;
  logic        pulse_out_ch0_en;
  logic        clr;
  logic        level;
  int          act_cnt;
  int          errors;
  int          num_checks;
  logic [7:0]  rd;
  int          divs[8] = '{2, 8, 32, 128, 256, 1024, 2048, 4096};
  logic [7:0]  dt[7] = '{8'h00, 8'h01, 8'h7D, 8'hF9, 8'hFA, 8'hFF, 8'h03};
  int          ex[7] = '{0, 2, 250, 498, 500, 500, 6};

  ebpwm_channel i_ebpwm_channel (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pulse_out_ch0(pulse_out_ch0),
    .pulse_out_ch0_en(pulse_out_ch0_en));
  ebpwm_load i_ebpwm_load (.clk(clk), .clr(clr), .pin(pulse_out_ch0),
    .pin_en(pulse_out_ch0_en), .level(level), .act_cnt(act_cnt));

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %0h got %0h", nm, exp, got);
    end
  endtask

  // waitrequest and readdata are taken at the rising edge, before the slave moves on
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int   n;
    logic w;
    n = 0;
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= {24'h00_0000, d};
    do begin
      @(posedge clk);
      w  = avs_waitrequest;
      rd = avs_readdata[7:0];
      n++;
    end while (w !== 1'b0 && n < 20);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (w !== 1'b0) begin
      chk("waitrequest", 16'h0000, 16'h0001);
      tally_and_finish();
    end
    @(posedge clk);
  endtask

  task automatic rc(input string nm, input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(nm, {8'h00, exp}, {8'h00, rd});
  endtask

  task automatic run(input logic [7:0] ctrl, input logic [7:0] duty, input int exp);
    bus(1'b1, 4'h0, ctrl & 8'h7F);
    bus(1'b1, 4'h4, duty);
    bus(1'b1, 4'h0, ctrl);
    repeat (510) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (500) @(posedge clk);
    #1;
    chk("active_clocks", exp[15:0], act_cnt[15:0]);
    @(posedge clk);
  endtask

  task automatic t_regs;
    chk("pin_en_rst", 16'h0000, {15'h0000, pulse_out_ch0_en});
    rc("ctrl_rst", 4'h0, 8'h38);
    rc("duty_rst", 4'h4, 8'hFF);
    rc("count_rst", 4'h8, 8'h00);
    bus(1'b1, 4'h0, 8'h07);
    rc("ctrl_rsv", 4'h0, 8'h3F);
    bus(1'b1, 4'h0, 8'h00);
    rc("ctrl_clr", 4'h0, 8'h38);
    bus(1'b1, 4'h8, 8'h55);
    rc("count_ro", 4'h8, 8'h00);
    bus(1'b1, 4'hC, 8'hAA);
    rc("unmapped", 4'hC, 8'h00);
    bus(1'b1, 4'h4, 8'h10);
    rc("duty_now", 4'h4, 8'h10);
    avs_byteenable <= 4'hE;
    bus(1'b1, 4'h4, 8'h22);
    avs_byteenable <= 4'hF;
    rc("duty_lane", 4'h4, 8'h10);
  endtask

  task automatic t_run;
    run(8'hC0, 8'h03, 494);
    for (int i = 0; i < 7; i++) begin
      run(8'h80, dt[i], ex[i]);
    end
    bus(1'b1, 4'h4, 8'h05);
    rc("duty_held", 4'h4, 8'h03);
    bus(1'b0, 4'h8, 8'h00);
    chk("count_top", 16'h0001, {15'h0000, rd <= 8'hF9});
    repeat (510) @(posedge clk);
    rc("duty_wrap", 4'h4, 8'h05);
    bus(1'b1, 4'h0, 8'h00);
    chk("pin_off", 16'h0000, {14'h0000, pulse_out_ch0_en, pulse_out_ch0});
    rc("count_off", 4'h8, 8'h00);
  endtask

  // one duty step is exactly one counter clock, so its width is the division
  task automatic t_div;
    int n;
    for (int s = 0; s < 8; s++) begin
      bus(1'b1, 4'h0, 8'(s));
      bus(1'b1, 4'h4, 8'h01);
      bus(1'b1, 4'h0, 8'h80 | 8'(s));
      if (s == 7) rc("count_start", 4'h8, 8'h00);
      // the pin is launched at this edge, so look only once it has settled
      #1;
      n = 0;
      while (level !== 1'b1 && n < 9000) begin
        @(posedge clk);
        #1;
        n++;
      end
      if (level !== 1'b1) begin
        chk("pulse_start", 16'h0001, 16'h0000);
        tally_and_finish();
      end
      n = 0;
      while (level === 1'b1 && n < 9000) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk("step_width", divs[s][15:0], n[15:0]);
      if (n >= 9000) tally_and_finish();
      @(posedge clk);
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst_n          = 1'b0;
    avs_address    = 4'h0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'hF;
    clr            = 1'b0;
    errors         = 0;
    num_checks     = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_run();
    t_div();
    tally_and_finish();
  end
endmodule // ebpwm_channel_tb
